// ### verilog/dcr_defs.svh
// Offsets, field positions and fixed values of the capability bank.
// Assumes a 16-bit word address and a 32-bit read data path.
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

////////////////////////////////////////////////////////////////////////
// Widths
`define DCR_ADDR_W 16
`define DCR_DATA_W 32

////////////////////////////////////////////////////////////////////////
// Register offsets (word addresses)
`define DCR_OFS_PART_ID 16'h0882
`define DCR_OFS_CAP_ONE 16'h0886
`define DCR_OFS_CAP_TWO 16'h0888
`define DCR_OFS_CAP_THREE 16'h088a

////////////////////////////////////////////////////////////////////////
// Capability word one fields
`define DCR_PART_NO_LSB 22
`define DCR_PART_NO_MSB 29
`define DCR_MATH_BIT 13
`define DCR_RAM_LSB 3
`define DCR_ONE_USED 32'h3fc0_2078

////////////////////////////////////////////////////////////////////////
// Capability word two fields
`define DCR_CAN_BIT 27
`define DCR_QEP_BIT 16
`define DCR_CAPTURE_BIT 12
`define DCR_I2C_BIT 8
`define DCR_SPI_BIT 4
`define DCR_SERIAL_LSB 0
`define DCR_TWO_USED 32'h0801_1117

////////////////////////////////////////////////////////////////////////
// Capability word three fields
`define DCR_TRIP_LSB 13
`define DCR_PWM_LSB 0
`define DCR_THREE_USED 32'h000f_e07f

////////////////////////////////////////////////////////////////////////
// Reset values
`define DCR_RD_RESET 32'h0000_0000

`endif

// ### verilog/dcr_pkg.sv
// Types shared by the capability bank and its read-only store.
// Assumes dcr_defs.svh is on the include path.
package dcr_pkg;

   ////////////////////////////////////////////////////////////////////
   // Register selected by an address
   typedef enum logic [2:0] {
      DCR_SEL_NONE = 3'b000,
      DCR_SEL_PART = 3'b001,
      DCR_SEL_ONE = 3'b010,
      DCR_SEL_TWO = 3'b011,
      DCR_SEL_THREE = 3'b100
   } dcr_sel_t;

   ////////////////////////////////////////////////////////////////////
   // State of the bus side of the bank
   typedef struct packed {
      logic rd_valid;
      logic acc_err;
      logic wr_ignored;
   } dcr_state_t;

   ////////////////////////////////////////////////////////////////////
   // State of the read-only store
   typedef struct packed {
      logic [31:0] rd_data;
   } dcr_rom_state_t;

endpackage : dcr_pkg

// ### verilog/dcr_rom.sv
// Read-only store of the four fixed words with a registered read port.
// Assumes the select is already decoded and the words never change.
`include "dcr_defs.svh"

module dcr_rom
   import dcr_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic rd_en, // Read strobe
   input wire dcr_sel_t sel, // Decoded register
   input wire logic [31:0] part_id, // Part identifier word
   input wire logic [31:0] cap_one, // Capability word one
   input wire logic [31:0] cap_two, // Capability word two
   input wire logic [31:0] cap_three, // Capability word three
   output logic [31:0] rd_data // Read data, one cycle after strobe
);

   dcr_rom_state_t st_q;
   dcr_rom_state_t st_d;

   ////////////////////////////////////////////////////////////////////
   // Data stand only in the cycle after a read, zero otherwise
   always_comb begin
      st_d = st_q;
      st_d.rd_data = `DCR_RD_RESET;
      if (rd_en) begin
         case (sel)
            DCR_SEL_PART: st_d.rd_data = part_id;
            DCR_SEL_ONE: st_d.rd_data = cap_one;
            DCR_SEL_TWO: st_d.rd_data = cap_two;
            DCR_SEL_THREE: st_d.rd_data = cap_three;
            default: st_d.rd_data = `DCR_RD_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data = st_q.rd_data;

endmodule : dcr_rom

// ### verilog/dcr_bank.sv
// Capability register bank: three fixed capability words and the
// part identifier, read over a plain strobe port.
// Assumes the master never raises both strobes in one cycle.
//
// The implementer's own choices: the register addresses and strobed register access.
`include "dcr_defs.svh"

// Functional notes
// - Word one bits 29:22 hold the part number, also the low byte of the part identifier.
// - Word one bit 13 shows the math accelerator; its reserved bits read zero.
// - Word one bits 3 to 6 show RAM blocks 0 to 3.
// - Word two bit 27 shows the CAN controller; its reserved bits read zero.
// - Word two bit 16 shows the encoder unit and bit 12 the capture unit.
// - Word two bit 8 shows the I2C port and bit 4 the SPI port.
// - Word two bits 0 to 2 show serial ports A to C.
// - Word three bits 13 to 19 show trip filters 1 to 7; its reserved bits read zero.
// - Word three bits 0 to 6 show PWM units 1 to 7.
// - A zero bit means the unit is absent; values are fixed per part.
module dcr_bank
   import dcr_pkg::*;
#(
   parameter logic [7:0] PART_NUMBER = 8'h00, // Arbitrary value
   parameter logic [7:0] PART_CLASS = 8'h00, // Arbitrary value
   parameter logic HAS_MATH = 1'b1,
   parameter logic [3:0] HAS_RAM = 4'hf,
   parameter logic HAS_CAN = 1'b1,
   parameter logic HAS_QEP = 1'b1,
   parameter logic HAS_CAPTURE = 1'b1,
   parameter logic HAS_I2C = 1'b1,
   parameter logic HAS_SPI = 1'b1,
   parameter logic [2:0] HAS_SERIAL = 3'h7,
   parameter logic [6:0] HAS_TRIP = 7'h7f,
   parameter logic [6:0] HAS_PWM = 7'h7f
) (
   input wire logic clk_sys, // System clock, 10 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [15:0] addr, // Word address
   input wire logic [31:0] wr_data, // Write data, ignored
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   output logic [31:0] rd_data, // Read data, cycle after strobe
   output logic rd_valid, // Marks read data
   output logic acc_err, // Access to an unmapped address
   output logic wr_ignored // Write to a mapped, fixed register
);

   ////////////////////////////////////////////////////////////////////
   // Address decode, shared by the bus logic and the checks
   function automatic dcr_sel_t dcr_decode(input logic [15:0] a);
      dcr_sel_t s;
      s = DCR_SEL_NONE;
      case (a)
         `DCR_OFS_PART_ID: s = DCR_SEL_PART;
         `DCR_OFS_CAP_ONE: s = DCR_SEL_ONE;
         `DCR_OFS_CAP_TWO: s = DCR_SEL_TWO;
         `DCR_OFS_CAP_THREE: s = DCR_SEL_THREE;
         default: s = DCR_SEL_NONE;
      endcase
      return s;
   endfunction : dcr_decode

   ////////////////////////////////////////////////////////////////////
   // Fixed words, taken from parameters only
   logic [31:0] part_id_w;
   logic [31:0] cap_one_w;
   logic [31:0] cap_two_w;
   logic [31:0] cap_three_w;
   logic [31:0] one_raw;
   logic [31:0] two_raw;
   logic [31:0] three_raw;

   // Part number placed once and mirrored
   always_comb begin
      part_id_w = {16'h0000, PART_CLASS, PART_NUMBER};
   end

   always_comb begin
      one_raw = `DCR_RD_RESET;
      one_raw[`DCR_PART_NO_MSB:`DCR_PART_NO_LSB] = PART_NUMBER;
      one_raw[`DCR_MATH_BIT] = HAS_MATH;
      one_raw[`DCR_RAM_LSB +: 4] = HAS_RAM;
   end

   always_comb begin
      two_raw = `DCR_RD_RESET;
      two_raw[`DCR_CAN_BIT] = HAS_CAN;
      two_raw[`DCR_QEP_BIT] = HAS_QEP;
      two_raw[`DCR_CAPTURE_BIT] = HAS_CAPTURE;
      two_raw[`DCR_I2C_BIT] = HAS_I2C;
      two_raw[`DCR_SPI_BIT] = HAS_SPI;
      two_raw[`DCR_SERIAL_LSB +: 3] = HAS_SERIAL;
   end

   // One bit per trip filter and per PWM unit
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_three
         if (gi >= `DCR_TRIP_LSB && gi < `DCR_TRIP_LSB + 7) begin : g_trip
            assign three_raw[gi] = HAS_TRIP[gi - `DCR_TRIP_LSB];
         end else if (gi >= `DCR_PWM_LSB && gi < `DCR_PWM_LSB + 7)
         begin : g_pwm
            assign three_raw[gi] = HAS_PWM[gi - `DCR_PWM_LSB];
         end else begin : g_reserved_bits
            assign three_raw[gi] = 1'b0;
         end
      end
   endgenerate

   // Reserved bits forced to zero; nothing here depends on bus writes
   always_comb begin
      cap_one_w = one_raw & `DCR_ONE_USED;
      cap_two_w = two_raw & `DCR_TWO_USED;
      cap_three_w = three_raw & `DCR_THREE_USED;
   end

   ////////////////////////////////////////////////////////////////////
   // Bus side state
   dcr_state_t st_q;
   dcr_state_t st_d;
   dcr_sel_t sel_w;

   always_comb begin
      sel_w = dcr_decode(addr);
   end

   always_comb begin
      st_d = st_q;
      st_d.rd_valid = rd_en;
      st_d.acc_err = (rd_en || wr_en) && (sel_w == DCR_SEL_NONE);
      // Writes are answered but never stored
      st_d.wr_ignored = wr_en && (sel_w != DCR_SEL_NONE);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_valid = st_q.rd_valid;
   assign acc_err = st_q.acc_err;
   assign wr_ignored = st_q.wr_ignored;

   ////////////////////////////////////////////////////////////////////
   // Registered read port
   dcr_rom u_rom (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rd_en(rd_en),
      .sel(sel_w),
      .part_id(part_id_w),
      .cap_one(cap_one_w),
      .cap_two(cap_two_w),
      .cap_three(cap_three_w),
      .rd_data(rd_data)
   );

   ////////////////////////////////////////////////////////////////////
   // Checks
   AST_PART_MIRROR:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_PART
      |=> rd_valid && rd_data[7:0] == PART_NUMBER)
   else $error("Part identifier low byte differs from part number");

   AST_PART_FIELD:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_ONE
      |=> rd_data[29:22] == PART_NUMBER)
   else $error("Part number field wrong in word one");

   AST_ONE_RESERVED_BITS:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_ONE
      |=> rd_data[31:30] == 2'b00 && rd_data[21:14] == 8'h00
         && rd_data[12:7] == 6'h00 && rd_data[2:0] == 3'h0
         && rd_data[13] == HAS_MATH)
   else $error("Word one reserved or math bit wrong");

   AST_ONE_RAM:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_ONE
      |=> rd_data[6:3] == HAS_RAM)
   else $error("RAM block bits wrong");

   AST_TWO_CAN:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_TWO
      |=> rd_data[27] == HAS_CAN && rd_data[31:28] == 4'h0
         && rd_data[26:17] == 10'h000 && rd_data[15:13] == 3'h0
         && rd_data[11:9] == 3'h0 && rd_data[7:5] == 3'h0
         && rd_data[3] == 1'b0)
   else $error("Word two CAN or reserved bits wrong");

   AST_TWO_UNITS:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_TWO
      |=> rd_data[16] == HAS_QEP && rd_data[12] == HAS_CAPTURE)
   else $error("Encoder or capture bit wrong");

   AST_TWO_PORTS:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_TWO
      |=> rd_data[8] == HAS_I2C && rd_data[4] == HAS_SPI)
   else $error("I2C or SPI bit wrong");

   AST_TWO_SERIAL:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_TWO
      |=> rd_data[2:0] == HAS_SERIAL)
   else $error("Serial port bits wrong");

   AST_THREE_TRIP:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_THREE
      |=> rd_data[19:13] == HAS_TRIP && rd_data[31:20] == 12'h000
         && rd_data[12:7] == 6'h00)
   else $error("Trip filter or reserved bits wrong");

   AST_THREE_PWM:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_THREE
      |=> rd_data[6:0] == HAS_PWM)
   else $error("PWM unit bits wrong");

   AST_SAME_TWICE:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en ##1 rd_en && addr == $past(addr)
      |=> rd_data == $past(rd_data))
   else $error("Back to back reads of one register differ");

   AST_WRITE_NO_EFFECT:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en && dcr_decode(addr) == DCR_SEL_ONE
      ##1 rd_en && dcr_decode(addr) == DCR_SEL_ONE
      |=> rd_data[29:22] == PART_NUMBER && rd_data[13] == HAS_MATH
         && wr_ignored == 1'b0 && rd_valid)
   else $error("Write changed a fixed register");

   AST_WRITE_FLAG:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en && dcr_decode(addr) != DCR_SEL_NONE
      |=> wr_ignored && !rd_valid && rd_data == 32'h0000_0000)
   else $error("Write to fixed register not flagged");

   AST_UNMAPPED:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_NONE
      |=> acc_err && rd_valid && rd_data == 32'h0000_0000)
   else $error("Unmapped read not answered with zero");

   AST_IDLE_ZERO:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rd_en |=> !rd_valid && rd_data == 32'h0000_0000)
   else $error("Read data outside the answer cycle");

   ////////////////////////////////////////////////////////////////////
   // Flag, framing, part identifier and write-then-read checks

   AST_RESET_QUIET:
   assert property (@(posedge clk_sys)
      !rst_n |=> !rd_valid && !acc_err && !wr_ignored
         && rd_data == 32'h0000_0000)
   else $error("Outputs not cleared by reset");

   AST_READ_VALID:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en |=> rd_valid && !wr_ignored)
   else $error("Read strobe not answered by valid");

   AST_MAPPED_OK:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en || wr_en) && dcr_decode(addr) != DCR_SEL_NONE |=> !acc_err)
   else $error("Mapped access flagged as an error");

   AST_UNMAPPED_WRITE:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en && dcr_decode(addr) == DCR_SEL_NONE
      |=> acc_err && !wr_ignored && !rd_valid && rd_data == 32'h0000_0000)
   else $error("Unmapped write not flagged");

   AST_FLAGS_QUIET:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rd_en && !wr_en |=> !acc_err && !wr_ignored)
   else $error("Flag raised without a strobe");

   AST_FLAGS_APART:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(acc_err && wr_ignored))
   else $error("Error and ignored write flags together");

   AST_ERR_ONLY_STROBE:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      acc_err |-> $past(rd_en) || $past(wr_en))
   else $error("Error flag without a strobe before it");

   AST_DATA_ONLY_READ:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rd_valid |-> rd_data == 32'h0000_0000)
   else $error("Read data without valid");

   AST_PART_UPPER:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_PART
      |=> rd_data[31:16] == 16'h0000 && rd_data[15:8] == PART_CLASS)
   else $error("Part identifier upper bytes wrong");

   AST_ONE_THEN_PART:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && dcr_decode(addr) == DCR_SEL_ONE
      ##1 rd_en && dcr_decode(addr) == DCR_SEL_PART
      |=> rd_data[7:0] == $past(rd_data[29:22]))
   else $error("Part field and part identifier disagree");

   AST_WRITE_TWO:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en && dcr_decode(addr) == DCR_SEL_TWO
      ##1 rd_en && dcr_decode(addr) == DCR_SEL_TWO
      |=> rd_data[27] == HAS_CAN && rd_data[16] == HAS_QEP
         && rd_data[12] == HAS_CAPTURE && rd_data[2:0] == HAS_SERIAL)
   else $error("Write changed word two");

   AST_WRITE_THREE:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en && dcr_decode(addr) == DCR_SEL_THREE
      ##1 rd_en && dcr_decode(addr) == DCR_SEL_THREE
      |=> rd_data[19:13] == HAS_TRIP && rd_data[6:0] == HAS_PWM)
   else $error("Write changed word three");

   AST_PART_NO_CHANGE:
   assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en && dcr_decode(addr) == DCR_SEL_PART
      ##1 rd_en && dcr_decode(addr) == DCR_SEL_PART
      |=> rd_data == {16'h0000, PART_CLASS, PART_NUMBER})
   else $error("Write changed the part identifier");

endmodule : dcr_bank

// ### bench/tb_device_capability_registers.sv
// Self-checking bench for the capability register bank.
// Assumes dcr_defs.svh on the include path and a 10 MHz system clock.
`include "dcr_defs.svh"

module tb_device_capability_registers;
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////
   // Part configuration, a mix of fitted and absent units
   localparam logic [7:0] PN = 8'ha5; // Arbitrary value
   localparam logic [7:0] PC = 8'h3c; // Arbitrary value
   localparam logic [3:0] RAM = 4'ha;
   localparam logic [2:0] SER = 3'h5;
   localparam logic [6:0] TRIP = 7'h55;
   localparam logic [6:0] PWM = 7'h2a;
   localparam logic QEP_FIT = 1'b0;
   localparam logic I2C_FIT = 1'b0;
   localparam logic [31:0] EXP_ID = {16'h0000, PC, PN};
   localparam logic [31:0] EXP_ONE = {2'b00, PN, 8'h00, 1'b1, 6'h00, RAM,
      3'b000};
   localparam logic [31:0] EXP_TWO = {4'h0, 1'b1, 10'h000, QEP_FIT, 3'b000,
      1'b1, 3'b000, I2C_FIT, 3'b000, 1'b1, 1'b0, SER};
   localparam logic [31:0] EXP_THREE = {12'h000, TRIP, 6'h00, PWM};

   logic clk_sys;
   logic rst_n;
   logic [15:0] addr;
   logic [31:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_data;
   logic rd_valid;
   logic acc_err;
   logic wr_ignored;
   int fails;
   int total_checks;

   dcr_bank #(.PART_NUMBER(PN), .PART_CLASS(PC), .HAS_MATH(1'b1),
      .HAS_RAM(RAM), .HAS_CAN(1'b1), .HAS_QEP(QEP_FIT), .HAS_CAPTURE(1'b1),
      .HAS_I2C(I2C_FIT), .HAS_SPI(1'b1), .HAS_SERIAL(SER), .HAS_TRIP(TRIP),
      .HAS_PWM(PWM)) uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .rd_valid(rd_valid), .acc_err(acc_err), .wr_ignored(wr_ignored));

   ////////////////////////////////////////////////////////////////////
   // Clock, report and bus tasks
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic end_of_test;
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
         input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check

   // One strobe; returns in the answer cycle with outputs settled
   task automatic access(input logic wr, input logic [15:0] a,
         input logic [31:0] d);
      @(posedge clk_sys);
      wr_en <= wr;
      rd_en <= !wr;
      addr <= a;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(negedge clk_sys);
   endtask : access

   task automatic flags(input logic [2:0] exp, input string msg);
      check({29'h0, rd_valid, acc_err, wr_ignored}, {29'h0, exp}, msg);
   endtask : flags

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic read_all;
      logic [15:0] ofs [4];
      logic [31:0] exp [4];
      ofs = '{`DCR_OFS_PART_ID, `DCR_OFS_CAP_ONE, `DCR_OFS_CAP_TWO,
         `DCR_OFS_CAP_THREE};
      exp = '{EXP_ID, EXP_ONE, EXP_TWO, EXP_THREE};
      for (int i = 0; i < 4; i++) begin
         access(1'b0, ofs[i], 32'h0000_0000);
         check(rd_data, exp[i], "read data");
         flags(3'b100, "read flags");
      end
   endtask : read_all

   task automatic write_fixed;
      logic [15:0] ofs [3];
      logic [31:0] exp [3];
      logic [31:0] used [3];
      ofs = '{`DCR_OFS_CAP_ONE, `DCR_OFS_CAP_TWO, `DCR_OFS_CAP_THREE};
      exp = '{EXP_ONE, EXP_TWO, EXP_THREE};
      used = '{`DCR_ONE_USED, `DCR_TWO_USED, `DCR_THREE_USED};
      for (int i = 0; i < 3; i++) begin
         // Reserved bits carry back what was read, every used field bit flips, fitted or absent
         @(posedge clk_sys);
         wr_en <= 1'b1;
         addr <= ofs[i];
         wr_data <= exp[i] ^ used[i];
         // Read follows the write with no gap
         @(posedge clk_sys);
         wr_en <= 1'b0;
         rd_en <= 1'b1;
         @(negedge clk_sys);
         flags(3'b001, "write flags");
         check(rd_data, 32'h0000_0000, "data after write");
         @(posedge clk_sys);
         rd_en <= 1'b0;
         @(negedge clk_sys);
         check(rd_data, exp[i], "read after write");
      end
   endtask : write_fixed

   task automatic unmapped;
      access(1'b0, 16'h0887, 32'h0000_0000);
      check(rd_data, 32'h0000_0000, "odd word read");
      flags(3'b110, "odd word read flags");
      access(1'b0, 16'h0884, 32'h0000_0000);
      flags(3'b110, "hole read flags");
      access(1'b1, 16'h0889, 32'hffff_ffff);
      flags(3'b010, "unmapped write flags");
      access(1'b0, `DCR_OFS_CAP_TWO, 32'h0000_0000);
      check(rd_data, EXP_TWO, "word two after stray write");
   endtask : unmapped

   task automatic back_to_back;
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr <= `DCR_OFS_CAP_THREE;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check(rd_data, EXP_THREE, "first of pair");
      @(posedge clk_sys);
      addr <= `DCR_OFS_CAP_ONE;
      @(negedge clk_sys);
      check(rd_data, EXP_THREE, "repeated read");
      @(posedge clk_sys);
      addr <= `DCR_OFS_PART_ID;
      @(negedge clk_sys);
      check(rd_data, EXP_ONE, "second of pair");
      @(posedge clk_sys);
      rd_en <= 1'b0;
      wr_en <= 1'b1;
      wr_data <= 32'h0000_0000;
      @(negedge clk_sys);
      check(rd_data, EXP_ID, "part id after word one");
      flags(3'b100, "read flags in pair");
      @(posedge clk_sys);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(negedge clk_sys);
      flags(3'b001, "write after reads");
      check(rd_data, 32'h0000_0000, "data after pair write");
      @(posedge clk_sys);
      rd_en <= 1'b0;
      @(negedge clk_sys);
      check(rd_data, EXP_ID, "part id after write");
      flags(3'b100, "read flags after write");
      @(negedge clk_sys);
      flags(3'b000, "idle after pair");
   endtask : back_to_back

   task automatic mid_reset;
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr <= `DCR_OFS_CAP_ONE;
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      @(negedge clk_sys);
      flags(3'b000, "flags in reset");
      check(rd_data, 32'h0000_0000, "data in reset");
      @(posedge clk_sys);
      rst_n <= 1'b1;
      access(1'b0, `DCR_OFS_PART_ID, 32'h0000_0000);
      check(rd_data, EXP_ID, "part id after reset");
   endtask : mid_reset

   ////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      fails = 0;
      total_checks = 0;
      rst_n = 1'b0;
      addr = 16'h0000;
      wr_data = 32'h0000_0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      flags(3'b000, "flags at reset");
      check(rd_data, 32'h0000_0000, "data at reset");
      @(posedge clk_sys);
      rst_n <= 1'b1;
      read_all();
      write_fixed();
      unmapped();
      back_to_back();
      mid_reset();
      end_of_test();
   end

   initial begin
      #100000;
      fails++;
      $display("MISMATCH %0t watchdog expired", $time);
      end_of_test();
   end

endmodule : tb_device_capability_registers
